/* src/ett_top.v */
// Three-channel 8-bit timer with wide timer and Avalon-MM registers
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ett_defs.vh"
module ett_top (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// External event inputs
	input  wire        timer_b_event_input,
	input  wire        timer_c_event_input,
	// Timer outputs and interrupt
	output reg         timer_a_output,
	output reg         timer_b_output,
	output reg         timer_c_output,
	output reg         irq
);
	// Software registers
	reg  [7:0]  timer_a_mode_control_reg;
	reg  [7:0]  timer_b_mode_control_reg;
	reg  [7:0]  carrier_output_control_reg;
	reg  [7:0]  timer_c_mode_control_reg;
	reg  [7:0]  timer_a_compare_reg;
	reg  [7:0]  timer_b_compare_reg;
	reg  [7:0]  timer_b_high_width_compare_reg;
	reg  [7:0]  timer_c_compare_reg;
	reg  [7:0]  timer_c_high_width_compare_reg;
	reg  [1:0]  wide_timer_clock_sel_reg;
	reg  [15:0] wide_cnt_reg;
	reg  [2:0]  irq_stat_reg;
	reg  [2:0]  irq_mask_reg;
	reg  [`ETT_PRE_W-1:0] pre_reg;
	reg         gate_reg;
	reg         b_out_prev_reg;
	// Synchronisers and edge detectors
	reg  [1:0]  evb_sync_reg;
	reg  [1:0]  evc_sync_reg;
	reg         evb_prev_reg;
	reg         evc_prev_reg;
	// Channel state
	wire [7:0]  a_cnt;
	wire [7:0]  b_cnt;
	wire [7:0]  c_cnt;
	wire        a_out;
	wire        b_out;
	wire        c_out;
	wire        a_match;
	wire        b_match;
	wire        c_match;
	wire        a_hit;
	wire        b_hit;
	// Decoded controls
	wire [1:0]  a_md;
	wire [1:0]  b_md;
	wire        casc;
	wire        carrier;
	wire [1:0]  a_mode;
	wire [1:0]  b_mode;
	wire [1:0]  c_mode;
	wire        en_a;
	wire        en_b;
	wire        en_c;
	wire [2:0]  a_csel;
	wire [2:0]  b_csel;
	wire [1:0]  c_csel;
	reg         a_tick;
	reg         b_tick_sel;
	reg         c_tick;
	reg         w_tick;
	wire        b_tick;
	wire        casc_clr;
	wire        evb_edge;
	wire        evc_edge;
	wire        tick8;
	wire        tick128;
	wire        b_rise;
	wire        wr_acc;
	wire        rd_acc;
	wire [2:0]  irq_ev;
	reg  [31:0] rd_next;

	// Mode decode: cascade needs both A and B in cascade
	assign a_md    = timer_a_mode_control_reg[`ETT_MODE_HI:`ETT_MODE_LO];
	assign b_md    = timer_b_mode_control_reg[`ETT_MODE_HI:`ETT_MODE_LO];
	assign casc    = (a_md == `ETT_MD_CASC) && (b_md == `ETT_MD_CASC);
	assign carrier = (b_md == `ETT_MD_CARR) && (a_md == `ETT_MD_ALONE);
	assign a_mode  = casc ? `ETT_MD_CASC :
			 (a_md == `ETT_MD_PWM) ? `ETT_MD_PWM : `ETT_MD_ALONE;
	assign b_mode  = casc ? `ETT_MD_CASC :
			 (b_md == `ETT_MD_ALONE) ? `ETT_MD_ALONE : `ETT_MD_PPG;
	assign c_mode  = timer_c_mode_control_reg[`ETT_MODE_LO] ? `ETT_MD_PPG
			 : `ETT_MD_ALONE;
	// In cascade the B enable runs and clears both halves
	assign en_a    = casc ? timer_b_mode_control_reg[`ETT_EN_BIT]
			 : timer_a_mode_control_reg[`ETT_EN_BIT];
	assign en_b    = timer_b_mode_control_reg[`ETT_EN_BIT];
	assign en_c    = timer_c_mode_control_reg[`ETT_EN_BIT];
	assign a_csel  = timer_a_mode_control_reg[`ETT_CSEL_HI:`ETT_CSEL_LO];
	assign b_csel  = timer_b_mode_control_reg[`ETT_CSEL_HI:`ETT_CSEL_LO];
	assign c_csel  = timer_c_mode_control_reg[`ETT_CSEL_C_HI:`ETT_CSEL_C_LO];

	// Prescaler taps and event edges
	assign tick8    = (pre_reg[2:0] == `ETT_PRE_DIV8);
	assign tick128  = (pre_reg == `ETT_PRE_DIV128);
	assign evb_edge = evb_sync_reg[1] & ~evb_prev_reg;
	assign evc_edge = evc_sync_reg[1] & ~evc_prev_reg;
	assign b_rise   = b_out & ~b_out_prev_reg;

	// Count clock selection per channel
	always @* begin
		case (a_csel)
		`ETT_CK_SYS:    a_tick = 1'b1;
		`ETT_CK_DIV8:   a_tick = tick8;
		`ETT_CK_DIV128: a_tick = tick128;
		`ETT_CK_BMAT:   a_tick = b_match;
		`ETT_CK_BOUT:   a_tick = b_rise;
		default:        a_tick = 1'b0;
		endcase
		case (b_csel)
		`ETT_CK_SYS:    b_tick_sel = 1'b1;
		`ETT_CK_DIV8:   b_tick_sel = tick8;
		`ETT_CK_DIV128: b_tick_sel = tick128;
		`ETT_CK_EXT:    b_tick_sel = evb_edge;
		default:        b_tick_sel = 1'b0;
		endcase
		case (c_csel)
		`ETT_CKC_SYS:  c_tick = 1'b1;
		`ETT_CKC_DIV8: c_tick = tick8;
		default:       c_tick = evc_edge;
		endcase
		case (wide_timer_clock_sel_reg)
		`ETT_CKW_CMAT: w_tick = c_match;
		`ETT_CKW_SYS:  w_tick = 1'b1;
		`ETT_CKW_DIV4: w_tick = (pre_reg[1:0] == `ETT_PRE_DIV4);
		default:       w_tick = (pre_reg[4:0] == `ETT_PRE_DIV32);
		endcase
	end

	// Cascade: B counts A's carries, both clear on joint match
	assign casc_clr = a_tick & a_hit & b_hit;
	// B also ticks on the joint match, else its half would never clear
	assign b_tick   = casc ? ((a_tick & (a_cnt == `ETT_CNT_TOP)) | casc_clr)
			  : b_tick_sel;

	// Channel A
	ett_chan u_chan_a (
		.clk       (clk),
		.rst_n     (rst_n),
		.en        (en_a),
		.tick      (a_tick),
		.ext_clr   (casc_clr),
		.mode      (a_mode),
		.cmp       (timer_a_compare_reg),
		.cmp_hi    (timer_a_compare_reg),
		.cnt_reg   (a_cnt),
		.out_reg   (a_out),
		.match_reg (a_match),
		.hit       (a_hit)
	);

	// Channel B
	ett_chan u_chan_b (
		.clk       (clk),
		.rst_n     (rst_n),
		.en        (en_b),
		.tick      (b_tick),
		.ext_clr   (casc_clr),
		.mode      (b_mode),
		.cmp       (timer_b_compare_reg),
		.cmp_hi    (timer_b_high_width_compare_reg),
		.cnt_reg   (b_cnt),
		.out_reg   (b_out),
		.match_reg (b_match),
		.hit       (b_hit)
	);

	// Channel C
	ett_chan u_chan_c (
		.clk       (clk),
		.rst_n     (rst_n),
		.en        (en_c),
		.tick      (c_tick),
		.ext_clr   (1'b0),
		.mode      (c_mode),
		.cmp       (timer_c_compare_reg),
		.cmp_hi    (timer_c_high_width_compare_reg),
		.cnt_reg   (c_cnt),
		.out_reg   (c_out),
		.match_reg (c_match),
		.hit       ()
	);

	// Interrupt events; A is silent in cascade
	assign irq_ev = {c_match, b_match, a_match & ~casc};

	// Bus handshake: one wait cycle, then the access completes
	assign wr_acc  = avs_write & ~avs_waitrequest;
	assign rd_acc  = avs_read & ~avs_waitrequest;

	// Read data mux
	always @* begin
		rd_next = 32'h00000000;
		case (avs_address)
		`ETT_ADR_A_MODE:   rd_next[7:0] = timer_a_mode_control_reg;
		`ETT_ADR_B_MODE:   rd_next[7:0] = timer_b_mode_control_reg;
		`ETT_ADR_CARRIER:  rd_next[7:0] = carrier_output_control_reg;
		`ETT_ADR_C_MODE:   rd_next[7:0] = timer_c_mode_control_reg;
		`ETT_ADR_A_CMP:    rd_next[7:0] = timer_a_compare_reg;
		`ETT_ADR_B_CMP:    rd_next[7:0] = timer_b_compare_reg;
		`ETT_ADR_B_HCMP:   rd_next[7:0] = timer_b_high_width_compare_reg;
		`ETT_ADR_C_CMP:    rd_next[7:0] = timer_c_compare_reg;
		`ETT_ADR_C_HCMP:   rd_next[7:0] = timer_c_high_width_compare_reg;
		`ETT_ADR_A_CNT:    rd_next[7:0] = a_cnt;
		`ETT_ADR_B_CNT:    rd_next[7:0] = b_cnt;
		`ETT_ADR_C_CNT:    rd_next[7:0] = c_cnt;
		`ETT_ADR_WIDE_CTL: rd_next[1:0] = wide_timer_clock_sel_reg;
		`ETT_ADR_WIDE_CNT: rd_next[23:0] = {wide_cnt_reg, c_cnt};
		`ETT_ADR_IRQ_STAT: rd_next[2:0] = irq_stat_reg;
		default:           rd_next[2:0] = irq_mask_reg;
		endcase
	end

	// Bus slave and register writes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest                <= 1'b1;
			avs_readdata                   <= 32'h00000000;
			timer_a_mode_control_reg       <= 8'h00;
			timer_b_mode_control_reg       <= 8'h00;
			carrier_output_control_reg     <= 8'h00;
			timer_c_mode_control_reg       <= 8'h00;
			timer_a_compare_reg            <= 8'h00;
			timer_b_compare_reg            <= 8'h00;
			timer_b_high_width_compare_reg <= 8'h00;
			timer_c_compare_reg            <= 8'h00;
			timer_c_high_width_compare_reg <= 8'h00;
			wide_timer_clock_sel_reg       <= 2'h0;
			irq_mask_reg                   <= 3'h0;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if ((avs_read | avs_write) & avs_waitrequest)
				avs_readdata <= avs_read ? rd_next : 32'h00000000;
			if (wr_acc) begin
				case (avs_address)
				`ETT_ADR_A_MODE:   timer_a_mode_control_reg <= avs_writedata[7:0];
				`ETT_ADR_B_MODE:   timer_b_mode_control_reg <= avs_writedata[7:0];
				`ETT_ADR_CARRIER:  carrier_output_control_reg <= avs_writedata[7:0];
				`ETT_ADR_C_MODE:   timer_c_mode_control_reg <= avs_writedata[7:0];
				`ETT_ADR_A_CMP:    timer_a_compare_reg <= avs_writedata[7:0];
				`ETT_ADR_B_CMP:    timer_b_compare_reg <= avs_writedata[7:0];
				`ETT_ADR_B_HCMP:   timer_b_high_width_compare_reg <= avs_writedata[7:0];
				`ETT_ADR_C_CMP:    timer_c_compare_reg <= avs_writedata[7:0];
				`ETT_ADR_C_HCMP:   timer_c_high_width_compare_reg <= avs_writedata[7:0];
				`ETT_ADR_WIDE_CTL: wide_timer_clock_sel_reg <= avs_writedata[1:0];
				`ETT_ADR_IRQ_MASK: irq_mask_reg <= avs_writedata[2:0];
				default: ;
				endcase
			end
		end
	end

	// Sticky status, cleared by a read; a new event wins over the clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= 3'h0;
			irq          <= 1'b0;
		end else begin
			if (rd_acc && avs_address == `ETT_ADR_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~avs_readdata[2:0]) | irq_ev; // Only bits read
			else
				irq_stat_reg <= irq_stat_reg | irq_ev;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Wide timer free runs and never clears
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wide_cnt_reg <= 16'h0000;
		else if (w_tick)
			wide_cnt_reg <= wide_cnt_reg + 16'h0001;
	end

	// Prescaler, synchronisers, edge history, carrier gate
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg        <= {`ETT_PRE_W{1'b0}};
			evb_sync_reg   <= 2'h0;
			evc_sync_reg   <= 2'h0;
			evb_prev_reg   <= 1'b0;
			evc_prev_reg   <= 1'b0;
			b_out_prev_reg <= 1'b0;
			gate_reg       <= 1'b0;
		end else begin
			pre_reg        <= pre_reg + {{(`ETT_PRE_W-1){1'b0}}, 1'b1};
			evb_sync_reg   <= {evb_sync_reg[0], timer_b_event_input};
			evc_sync_reg   <= {evc_sync_reg[0], timer_c_event_input};
			evb_prev_reg   <= evb_sync_reg[1];
			evc_prev_reg   <= evc_sync_reg[1];
			b_out_prev_reg <= b_out;
			if (!carrier)
				gate_reg <= 1'b0;
			else if (a_match)
				gate_reg <= ~gate_reg;
		end
	end

	// Output pins, enabled per channel
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_a_output <= 1'b0;
			timer_b_output <= 1'b0;
			timer_c_output <= 1'b0;
		end else begin
			timer_a_output <= timer_a_mode_control_reg[`ETT_OE_BIT] & a_out;
			if (carrier && carrier_output_control_reg[`ETT_GATE_BIT])
				timer_b_output <= timer_b_mode_control_reg[`ETT_OE_BIT]
						  & b_out & gate_reg;
			else
				timer_b_output <= timer_b_mode_control_reg[`ETT_OE_BIT] & b_out;
			timer_c_output <= timer_c_mode_control_reg[`ETT_OE_BIT] & c_out;
		end
	end
endmodule // ett_top
`default_nettype wire

/* src/ett_defs.vh */
// Constants for the three-channel 8-bit timer block
`ifndef ETT_DEFS_VH
`define ETT_DEFS_VH

// Register word indexes on the Avalon slave
`define ETT_ADR_A_MODE   4'h0
`define ETT_ADR_B_MODE   4'h1
`define ETT_ADR_CARRIER  4'h2
`define ETT_ADR_C_MODE   4'h3
`define ETT_ADR_A_CMP    4'h4
`define ETT_ADR_B_CMP    4'h5
`define ETT_ADR_B_HCMP   4'h6
`define ETT_ADR_C_CMP    4'h7
`define ETT_ADR_C_HCMP   4'h8
`define ETT_ADR_A_CNT    4'h9
`define ETT_ADR_B_CNT    4'ha
`define ETT_ADR_C_CNT    4'hb
`define ETT_ADR_WIDE_CTL 4'hc
`define ETT_ADR_WIDE_CNT 4'hd
`define ETT_ADR_IRQ_STAT 4'he
`define ETT_ADR_IRQ_MASK 4'hf

// Mode control fields
`define ETT_EN_BIT    7
`define ETT_CSEL_HI   5
`define ETT_CSEL_LO   3
`define ETT_MODE_HI   2
`define ETT_MODE_LO   1
`define ETT_OE_BIT    0
`define ETT_CSEL_C_HI 5
`define ETT_CSEL_C_LO 4
`define ETT_GATE_BIT  0

// Channel modes
`define ETT_MD_ALONE 2'h0
`define ETT_MD_CASC  2'h1
`define ETT_MD_PWM   2'h2
`define ETT_MD_PPG   2'h3
`define ETT_MD_CARR  2'h2

// Count clock selections
`define ETT_CK_SYS   3'h0
`define ETT_CK_DIV8  3'h1
`define ETT_CK_DIV128 3'h2
`define ETT_CK_EXT   3'h3
`define ETT_CK_BMAT  3'h3
`define ETT_CK_BOUT  3'h4
`define ETT_CKC_SYS  2'h0
`define ETT_CKC_DIV8 2'h3
`define ETT_CKW_CMAT 2'h0
`define ETT_CKW_SYS  2'h1
`define ETT_CKW_DIV4 2'h2

// Prescaler tap values
`define ETT_PRE_W     7
`define ETT_PRE_DIV4  2'h3
`define ETT_PRE_DIV8  3'h7
`define ETT_PRE_DIV32 5'h1f
`define ETT_PRE_DIV128 7'h7f

// Counter constants
`define ETT_CNT_ZERO 8'h00
`define ETT_CNT_TOP  8'hff
`define ETT_IRQ_W    3

`endif

/* src/ett_chan.v */
// One 8-bit timer channel: counter, compare, output waveform
`timescale 1ns/1ns
`default_nettype none
`include "ett_defs.vh"
module ett_chan (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Control
	input  wire       en,
	input  wire       tick,
	input  wire       ext_clr,
	input  wire [1:0] mode,
	input  wire [7:0] cmp,
	input  wire [7:0] cmp_hi,
	// State
	output reg  [7:0] cnt_reg,
	output reg        out_reg,
	output reg        match_reg,
	output wire       hit
);
	reg        phase_reg;
	wire [7:0] cnt_inc;
	wire       hit_hi;

	assign hit     = (cnt_reg == cmp);
	assign hit_hi  = (cnt_reg == cmp_hi);
	assign cnt_inc = cnt_reg + 8'h01;

	// Counter and waveform per mode
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= `ETT_CNT_ZERO;
			out_reg   <= 1'b0;
			match_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else if (!en) begin
			cnt_reg   <= `ETT_CNT_ZERO;
			out_reg   <= 1'b0;
			match_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else begin
			match_reg <= 1'b0;
			if (tick) begin
				case (mode)
				`ETT_MD_ALONE: begin
					// Match clears, overflow wraps to zero
					if (hit) begin
						cnt_reg   <= `ETT_CNT_ZERO;
						match_reg <= 1'b1;
						out_reg   <= ~out_reg;
					end else begin
						cnt_reg <= cnt_inc;
					end
				end
				`ETT_MD_CASC: begin
					// Clear decided by the pair, not this half
					if (ext_clr) begin
						cnt_reg   <= `ETT_CNT_ZERO;
						match_reg <= 1'b1;
						out_reg   <= ~out_reg;
					end else begin
						cnt_reg <= cnt_inc;
					end
				end
				`ETT_MD_PWM: begin
					// Free running; high from overflow until match
					cnt_reg <= cnt_inc;
					if (cnt_reg == `ETT_CNT_TOP)
						out_reg <= 1'b1;
					else if (hit) begin
						out_reg   <= 1'b0;
						match_reg <= 1'b1;
					end
				end
				default: begin
					// Low phase ends on compare, high phase on high compare
					if ((!phase_reg && hit) || (phase_reg && hit_hi)) begin
						cnt_reg   <= `ETT_CNT_ZERO;
						phase_reg <= ~phase_reg;
						out_reg   <= ~phase_reg;
						match_reg <= 1'b1;
					end else begin
						cnt_reg <= cnt_inc;
					end
				end
				endcase
			end
		end
	end
endmodule // ett_chan
`default_nettype wire

/* sim/ett_top_sva.sv */
// Port checker for the three-channel timer block
`timescale 1ns/1ns
`default_nettype none
module ett_top_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Avalon-MM slave
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins
	input wire logic        timer_b_event_input,
	input wire logic        timer_c_event_input,
	input wire logic        timer_a_output,
	input wire logic        timer_b_output,
	input wire logic        timer_c_output,
	input wire logic        irq
);
	logic       wr_done;
	logic [2:0] oe_reg;
	logic [2:0] mask_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A write that completes at this edge
	assign wr_done = !avs_waitrequest && avs_write;
	// Shadow copies of the output enables and the interrupt mask
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_reg   <= 3'h0;
			mask_reg <= 3'h0;
		end else if (wr_done) begin
			if (avs_address == 4'h0) oe_reg[0] <= avs_writedata[0];
			if (avs_address == 4'h1) oe_reg[1] <= avs_writedata[0];
			if (avs_address == 4'h3) oe_reg[2] <= avs_writedata[0];
			if (avs_address == 4'hf) mask_reg <= avs_writedata[2:0];
		end
	end
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	byte_read_a: assert property (!avs_waitrequest && avs_read && avs_address != 4'hd
		|-> avs_readdata[31:8] == 24'h0)
		else $error("register read has bits above the byte");
	wide_read_a: assert property (!avs_waitrequest && avs_read && avs_address == 4'hd
		|-> avs_readdata[31:24] == 8'h0)
		else $error("24-bit read has bits above bit 23");
	mask_back_a: assert property (!avs_waitrequest && avs_read && avs_address == 4'hf
		|-> avs_readdata[2:0] == mask_reg)
		else $error("mask readback differs");
	irq_masked_a: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
		else $error("irq high with all sources masked");
	a_pin_off_a: assert property (!(oe_reg[0] | $past(oe_reg[0]) | $past(oe_reg[0], 2)
		| $past(oe_reg[0], 3)) |-> !timer_a_output)
		else $error("timer a pin high while disabled");
	b_pin_off_a: assert property (!(oe_reg[1] | $past(oe_reg[1]) | $past(oe_reg[1], 2)
		| $past(oe_reg[1], 3)) |-> !timer_b_output)
		else $error("timer b pin high while disabled");
	c_pin_off_a: assert property (!(oe_reg[2] | $past(oe_reg[2]) | $past(oe_reg[2], 2)
		| $past(oe_reg[2], 3)) |-> !timer_c_output)
		else $error("timer c pin high while disabled");
	// Main scenarios reached
	wide_read_c: cover property (!avs_waitrequest && avs_read && avs_address == 4'hd);
	irq_rise_c: cover property ($rose(irq));
	b_rise_c: cover property ($rose(timer_b_output));
	c_rise_c: cover property ($rose(timer_c_output));
endmodule // ett_top_sva
bind ett_top ett_top_sva u_sva (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .timer_b_event_input,
	.timer_c_event_input, .timer_a_output, .timer_b_output, .timer_c_output, .irq);
`default_nettype wire

/* sim/ett_pins.sv */
// Model of the external event sources feeding timers b and c
`timescale 1ns/1ns
`default_nettype none
module ett_pins (
	// Clock
	input wire logic clk,
	// Event pins
	output var logic timer_b_event_input,
	output var logic timer_c_event_input
);
	// Pins idle low
	initial begin
		timer_b_event_input = 1'b0;
		timer_c_event_input = 1'b0;
	end
	// Send n rising edges, each level held three cycles to clear the synchroniser
	task automatic pulses(input int ch, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			repeat (3) @(posedge clk);
			if (ch == 0)
				timer_b_event_input <= ~timer_b_event_input;
			else
				timer_c_event_input <= ~timer_c_event_input;
		end
		repeat (6) @(posedge clk);
	endtask
endmodule // ett_pins
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the three-channel timer block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clk;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        timer_b_event_input;
	logic        timer_c_event_input;
	logic        timer_a_output;
	logic        timer_b_output;
	logic        timer_c_output;
	logic        irq;
	logic [31:0] rd;
	int          n_mismatch;
	int          n_tests;
	int          cyc = 0;
	int          shadow [16];
	int          mode_adr [3] = '{0, 1, 3};
	int          cmp_adr [3]  = '{4, 5, 7};
	int          a;
	int          b;
	int          n;
	int          base;
	// Device and event source
	ett_top uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .timer_b_event_input, .timer_c_event_input,
		.timer_a_output, .timer_b_output, .timer_c_output, .irq);
	ett_pins pins (.clk, .timer_b_event_input, .timer_c_event_input);
	// Clock and cycle count
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// Verdict and end of run
	task automatic report_and_stop();
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang(input string what);
		$display("FAIL %s expected answer seen none", what);
		n_mismatch++;
		report_and_stop();
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// One Avalon access; read data land in rd, the model keeps written bytes
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_address   <= adr;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 20)
			hang("bus answer");
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (wr)
			shadow[adr] = d[7:0];
	endtask
	function automatic logic sig(input int s);
		return s == 3 ? irq : s == 2 ? timer_c_output : s == 1 ? timer_b_output : timer_a_output;
	endfunction
	// Wait for a rising edge of an output
	task automatic rise(input int s);
		logic prev;
		prev = sig(s);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			if (sig(s) === 1'b1 && prev !== 1'b1)
				return;
			prev = sig(s);
		end
		hang("output edge");
	endtask
	// Cycles between two rising edges; irq is cleared by a status read between them
	task automatic per(input int s, input int exp, input string what);
		int t;
		if (s == 3)
			bus(0, 4'he, 0);
		rise(s);
		t = cyc;
		if (s == 3)
			bus(0, 4'he, 0);
		rise(s);
		check(what, exp, cyc - t);
	endtask
	task automatic stop();
		for (int k = 0; k < 4; k++)
			bus(1, 4'(k), 0);
		bus(1, 4'hf, 0);
		bus(0, 4'he, 0);
	endtask
	// Main sequence
	initial begin
		rst_n         = 1'b0;
		avs_address   = 4'h0;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		n_mismatch    = 0;
		n_tests       = 0;
		void'($urandom(32'hcc0c));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			bus(0, 4'(k), 0);
			check("reset value", 0, rd);
		end
		for (int k = 4; k < 9; k++) begin
			bus(1, 4'(k), $urandom);
			bus(0, 4'(k), 0);
			check("compare readback", shadow[k], rd);
		end
		bus(1, 4'hf, $urandom % 8);
		bus(0, 4'hf, 0);
		check("mask readback", shadow[15] % 8, rd);
		bus(1, 4'h9, 32'hff);
		bus(0, 4'h9, 0);
		check("counter write ignored", 0, rd);
		stop();
		// Stand-alone square wave and interval on each channel
		for (int k = 0; k < 3; k++) begin
			a = 40 + $urandom % 60;
			bus(1, 4'(cmp_adr[k]), a);
			bus(1, 4'(mode_adr[k]), 32'h81);
			per(k, 2 * (a + 1), "square period");
			bus(1, 4'hf, 1 << k);
			per(3, a + 1, "interval period");
			bus(0, 4'he, 0);
			check("status source", 1 << k, rd);
			stop();
		end
		// Output enable off keeps the pin low
		bus(1, 4'h4, 3);
		bus(1, 4'h0, 32'h80);
		n = 0;
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			n += (timer_a_output !== 1'b0);
		end
		check("disabled pin highs", 0, n);
		stop();
		// Cascade: one joint interrupt per 16-bit period
		a = $urandom % 256;
		bus(1, 4'h4, a);
		bus(1, 4'h5, 1);
		bus(1, 4'h0, 32'h02);
		bus(1, 4'h1, 32'h82);
		bus(1, 4'hf, 3);
		per(3, 256 + a + 1, "cascade period");
		bus(0, 4'he, 0);
		check("cascade status", 2, rd);
		stop();
		// Free-running width modulation
		bus(1, 4'h4, 32'h40);
		bus(1, 4'h0, 32'h85);
		per(0, 256, "pwm period");
		stop();
		// Pulse output on b and c
		for (int k = 1; k < 3; k++) begin
			a = 10 + $urandom % 50;
			b = 10 + $urandom % 50;
			bus(1, 4'(cmp_adr[k]), a);
			bus(1, 4'(cmp_adr[k] + 1), b);
			bus(1, 4'(mode_adr[k]), k == 1 ? 32'h87 : 32'h83);
			per(k, a + b + 2, "pulse period");
			stop();
		end
		// Carrier: free then gated by timer a
		bus(1, 4'h5, 20);
		bus(1, 4'h6, 30);
		bus(1, 4'h1, 32'h85);
		per(1, 52, "carrier period");
		bus(1, 4'h4, 32'hc8);
		bus(1, 4'h2, 1);
		bus(1, 4'h0, 32'h80);
		n = 0;
		for (int i = 0; i < 804; i++) begin
			@(posedge clk);
			n += (timer_b_output === 1'b1);
		end
		check("gated carrier", 1, n > 0 && n < 400);
		stop();
		// External events on b
		bus(1, 4'h5, 32'hff);
		bus(1, 4'h1, 32'h98);
		n = 20 + $urandom % 200;
		pins.pulses(0, n);
		bus(0, 4'ha, 0);
		check("event count", n, rd);
		stop();
		// 24-bit event counting with both external clock codes
		bus(1, 4'h7, 32'hff);
		for (int k = 0; k < 2; k++) begin
			bus(0, 4'hd, 0);
			base = rd;
			bus(1, 4'h3, k == 0 ? 32'h90 : 32'ha0);
			n = 260 + $urandom % 200;
			pins.pulses(1, n);
			bus(0, 4'hd, 0);
			check("24-bit count", (base + n) % 32'h1000000, rd);
			bus(1, 4'h3, 0);
		end
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
